// ===== src/atr_defines.svh
// Offsets, field positions, reset values and counts for the angle and turns readout.
`ifndef ATR_DEFINES_SVH
`define ATR_DEFINES_SVH

`define ATR_OFS_PRIM_ANGLE 8'h10
`define ATR_OFS_PRIM_TURNS 8'h15
`define ATR_OFS_HYST_ANGLE 8'h16
`define ATR_OFS_VELOCITY 8'h17
`define ATR_OFS_ACCEL 8'h18
`define ATR_OFS_SECONDARY_ANGLE 8'h19
`define ATR_OFS_SEC_SNAP 8'h1a
`define ATR_OFS_PRIM_TURNS_SNAP 8'h1b
`define ATR_OFS_SEC_TURNS 8'h1c

`define ATR_BIT_WARN 13
`define ATR_BIT_OVF 12

`define ATR_FLT_PRIM_VOLT 0
`define ATR_FLT_SEC_VOLT 1
`define ATR_FLT_OSC 2
`define ATR_FLT_FIELD_HIGH 3
`define ATR_FLT_FIELD_LOW 4
`define ATR_FLT_SUPPLY_UV 5

`define ATR_PRI_TURN_MAX 11'h3ff
`define ATR_PRI_TURN_MIN 11'h400
`define ATR_SEC_TURN_MAX 11'h3ff
`define ATR_SEC_TURN_MIN 11'h401

`define ATR_BIST_CYCLES 8
`define ATR_HYST_SHIFT 2
`define ATR_RST_WORD 16'h0000

`endif

// ===== src/atr_pkg.sv
// Types shared by the angle and turns readout.
`include "atr_defines.svh"
package atr_pkg;

    typedef enum logic {
        ATR_BIST_IDLE = 1'b0,
        ATR_BIST_RUN = 1'b1
    } atr_bist_t;

    typedef struct packed {
        atr_bist_t bist_state;
        logic [7:0] bist_cnt;
        logic bist_fail;
        logic lp_prev;
        logic primed;
        logic [1:0][10:0] turns;
        logic [1:0] ovf;
        logic [1:0] warn;
        logic [15:0] prim_angle;
        logic [15:0] secondary_angle;
        logic [15:0] vel;
        logic [15:0] accel;
        logic [15:0] hyst_angle;
        logic [15:0] sec_snap;
        logic [15:0] prim_turns_snap;
        logic [15:0] rd_data;
    } atr_state_t;

    function automatic logic [15:0] atr_turns_word(input logic warn, input logic ovf, input logic [10:0] cnt);
        atr_turns_word = {2'h0, warn, ovf, 1'h0, cnt};
    endfunction : atr_turns_word

endpackage : atr_pkg

// ===== src/atr_readout.sv
// Angle and turns result registers with read-triggered snapshots and stuck-at-zero self-test.
`timescale 1ns/10ps
module atr_readout
    import atr_pkg::*;
#(
    parameter int BIST_CYCLES = `ATR_BIST_CYCLES,
    parameter int HYST_SHIFT = `ATR_HYST_SHIFT
) (
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_B_I,
    // Angle samples from the signal path
    input wire logic SAMPLE_I,
    input wire logic [15:0] PRIM_ANGLE_I,
    input wire logic [15:0] SECONDARY_ANGLE_I,
    // Encoder output configuration
    input wire logic ENC_CHAN_SEL_I,
    input wire logic [2:0] HYSTERESIS_SETTING_I,
    // Faults, low power and turns-count reset command
    input wire logic [5:0] FAULT_I,
    input wire logic LOW_POWER_I,
    input wire logic TURNS_RESET_I,
    // Host register read port
    input wire logic RD_EN_I,
    input wire logic [7:0] RD_ADDR_I,
    output logic [15:0] RD_DATA_O,
    // Derived outputs
    output logic [15:0] ENCODER_OUTPUT_ANGLE_O,
    output logic BIST_FORCE_O
);

    localparam logic [7:0] BIST_LAST = 8'(BIST_CYCLES - 1);
    localparam logic [1:0][10:0] TURN_MAX = {`ATR_SEC_TURN_MAX, `ATR_PRI_TURN_MAX};
    localparam logic [1:0][10:0] TURN_MIN = {`ATR_SEC_TURN_MIN, `ATR_PRI_TURN_MIN};

    atr_state_t st_reg;
    atr_state_t st_next;

    logic lp_exit;
    logic prim_fault;
    logic sec_fault;
    logic [1:0][15:0] new_ang;
    logic [1:0][15:0] old_ang;
    logic [1:0] step;
    logic step_up;
    logic step_dn;
    logic ovf_set;
    logic [15:0] sel_angle;
    logic [15:0] delta;
    logic [15:0] mag;
    logic [15:0] thresh;
    logic [15:0] vel_new;
    logic prim_read;

    always_comb begin
        st_next = st_reg;
        step = 2'h0;
        step_up = 1'b0;
        step_dn = 1'b0;
        ovf_set = 1'b0;
        new_ang = {SECONDARY_ANGLE_I, PRIM_ANGLE_I};
        old_ang = {st_reg.secondary_angle, st_reg.prim_angle};
        lp_exit = st_reg.lp_prev & ~LOW_POWER_I;
        st_next.lp_prev = LOW_POWER_I;

        unique case (st_reg.bist_state)
            ATR_BIST_IDLE: begin
                if (lp_exit) begin
                    st_next.bist_state = ATR_BIST_RUN;
                    st_next.bist_cnt = 8'h00;
                end
            end
            ATR_BIST_RUN: begin
                st_next.bist_cnt = st_reg.bist_cnt + 8'h01;
                if (st_reg.bist_cnt == BIST_LAST) begin
                    st_next.bist_state = ATR_BIST_IDLE;
                    if (!(&FAULT_I)) begin
                        st_next.bist_fail = 1'b1;
                    end
                end
            end
        endcase

        // The forced faults of the self-test are kept off the warning bits.
        prim_fault = FAULT_I[`ATR_FLT_PRIM_VOLT] | FAULT_I[`ATR_FLT_OSC] | FAULT_I[`ATR_FLT_SUPPLY_UV];
        sec_fault = FAULT_I[`ATR_FLT_SEC_VOLT] | FAULT_I[`ATR_FLT_OSC] | FAULT_I[`ATR_FLT_FIELD_HIGH]
                  | FAULT_I[`ATR_FLT_FIELD_LOW] | FAULT_I[`ATR_FLT_SUPPLY_UV];
        st_next.warn[0] = (prim_fault & (st_reg.bist_state == ATR_BIST_IDLE)) | st_next.bist_fail;
        st_next.warn[1] = (sec_fault & (st_reg.bist_state == ATR_BIST_IDLE)) | st_next.bist_fail;

        // A quadrant move of one step counts; a jump of two quadrants is ambiguous and ignored.
        for (int ch = 0; ch < 2; ch++) begin
            step = new_ang[ch][15:14] - old_ang[ch][15:14];
            step_up = SAMPLE_I & st_reg.primed & (step == 2'h1);
            step_dn = SAMPLE_I & st_reg.primed & (step == 2'h3);
            ovf_set = (step_up & (st_reg.turns[ch] == TURN_MAX[ch]))
                    | (step_dn & (st_reg.turns[ch] == TURN_MIN[ch]));
            if (TURNS_RESET_I) begin
                st_next.turns[ch] = 11'h000;
            end else if (step_up) begin
                st_next.turns[ch] = st_reg.turns[ch] + 11'h001;
            end else if (step_dn) begin
                st_next.turns[ch] = st_reg.turns[ch] - 11'h001;
            end
            st_next.ovf[ch] = ovf_set | (st_reg.ovf[ch] & ~TURNS_RESET_I);
        end

        vel_new = PRIM_ANGLE_I - st_reg.prim_angle;
        sel_angle = ENC_CHAN_SEL_I ? SECONDARY_ANGLE_I : PRIM_ANGLE_I;
        delta = sel_angle - st_reg.hyst_angle;
        mag = delta[15] ? (16'h0000 - delta) : delta;
        thresh = 16'(16'(HYSTERESIS_SETTING_I) << HYST_SHIFT);

        if (SAMPLE_I) begin
            st_next.primed = 1'b1;
            st_next.prim_angle = PRIM_ANGLE_I;
            st_next.secondary_angle = SECONDARY_ANGLE_I;
            if (st_reg.primed) begin
                st_next.vel = vel_new;
                st_next.accel = vel_new - st_reg.vel;
                if (mag > thresh) begin
                    st_next.hyst_angle = sel_angle;
                end
            end else begin
                st_next.hyst_angle = sel_angle;
            end
        end

        prim_read = RD_EN_I & (RD_ADDR_I == `ATR_OFS_PRIM_ANGLE);
        if (RD_EN_I) begin
            case (RD_ADDR_I)
                `ATR_OFS_PRIM_ANGLE: st_next.rd_data = st_reg.prim_angle;
                `ATR_OFS_PRIM_TURNS: st_next.rd_data = atr_turns_word(st_reg.warn[0], st_reg.ovf[0], st_reg.turns[0]);
                `ATR_OFS_HYST_ANGLE: st_next.rd_data = st_reg.hyst_angle;
                `ATR_OFS_VELOCITY: st_next.rd_data = st_reg.vel;
                `ATR_OFS_ACCEL: st_next.rd_data = st_reg.accel;
                `ATR_OFS_SECONDARY_ANGLE: st_next.rd_data = st_reg.secondary_angle;
                `ATR_OFS_SEC_SNAP: st_next.rd_data = st_reg.sec_snap;
                `ATR_OFS_PRIM_TURNS_SNAP: st_next.rd_data = st_reg.prim_turns_snap;
                `ATR_OFS_SEC_TURNS: st_next.rd_data = atr_turns_word(st_reg.warn[1], st_reg.ovf[1], st_reg.turns[1]);
                default: st_next.rd_data = 16'h0000;
            endcase
        end

        if (prim_read) begin
            st_next.sec_snap = st_reg.secondary_angle;
            st_next.prim_turns_snap = atr_turns_word(st_reg.warn[0], st_reg.ovf[0], st_reg.turns[0]);
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            st_reg <= '{
                bist_state: ATR_BIST_RUN,
                bist_cnt: 8'h00,
                bist_fail: 1'b0,
                lp_prev: 1'b0,
                primed: 1'b0,
                turns: '0,
                ovf: 2'h0,
                warn: 2'h0,
                prim_angle: `ATR_RST_WORD,
                secondary_angle: `ATR_RST_WORD,
                vel: `ATR_RST_WORD,
                accel: `ATR_RST_WORD,
                hyst_angle: `ATR_RST_WORD,
                sec_snap: `ATR_RST_WORD,
                prim_turns_snap: `ATR_RST_WORD,
                rd_data: `ATR_RST_WORD
            };
        end else begin
            st_reg <= st_next;
        end
    end

    assign RD_DATA_O = st_reg.rd_data;
    assign ENCODER_OUTPUT_ANGLE_O = st_reg.hyst_angle;
    assign BIST_FORCE_O = (st_reg.bist_state == ATR_BIST_RUN);

    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RST_B_I);

    property p_sec_snap;
        RD_EN_I && (RD_ADDR_I == `ATR_OFS_PRIM_ANGLE)
            |=> (st_reg.sec_snap == $past(st_reg.secondary_angle)) && (RD_DATA_O == $past(st_reg.prim_angle));
    endproperty
    a_sec_snap: assert property (p_sec_snap)
        else $error("secondary angle snapshot not taken on primary angle read");

    property p_turns_snap;
        RD_EN_I && (RD_ADDR_I == `ATR_OFS_PRIM_ANGLE)
            |=> (st_reg.prim_turns_snap[10:0] == $past(st_reg.turns[0]))
                && (st_reg.prim_turns_snap[12] == $past(st_reg.ovf[0]))
                && (st_reg.prim_turns_snap[13] == $past(st_reg.warn[0]));
    endproperty
    a_turns_snap: assert property (p_turns_snap)
        else $error("primary turns snapshot does not match the turns word");

    property p_sec_warn;
        (FAULT_I[`ATR_FLT_FIELD_HIGH] || FAULT_I[`ATR_FLT_FIELD_LOW] || FAULT_I[`ATR_FLT_SEC_VOLT])
            && !BIST_FORCE_O |=> st_reg.warn[1];
    endproperty
    a_sec_warn: assert property (p_sec_warn)
        else $error("secondary warning missing while a fault is set");

    property p_bist_start;
        !BIST_FORCE_O && $fell(LOW_POWER_I) |=> BIST_FORCE_O && (st_reg.bist_cnt == 8'h00);
    endproperty
    a_bist_start: assert property (p_bist_start)
        else $error("self-test did not run after leaving low power");

    property p_fail_sticky;
        st_reg.bist_fail |=> st_reg.bist_fail && st_reg.warn[1];
    endproperty
    a_fail_sticky: assert property (p_fail_sticky)
        else $error("self-test failure lost before reset");

    property p_ovf_clear;
        $fell(st_reg.ovf[1]) || $fell(st_reg.ovf[0]) |-> $past(TURNS_RESET_I);
    endproperty
    a_ovf_clear: assert property (p_ovf_clear)
        else $error("overflow flag cleared without the turns reset command");

    property p_sec_ovf;
        SAMPLE_I && st_reg.primed && !TURNS_RESET_I && (st_reg.turns[1] == 11'h3ff)
            && (SECONDARY_ANGLE_I[15:14] == st_reg.secondary_angle[15:14] + 2'h1) |=> st_reg.ovf[1];
    endproperty
    a_sec_ovf: assert property (p_sec_ovf)
        else $error("secondary overflow not flagged at the top of the range");

    property p_pri_ovf;
        SAMPLE_I && st_reg.primed && (st_reg.turns[0] == 11'h400)
            && (PRIM_ANGLE_I[15:14] == st_reg.prim_angle[15:14] - 2'h1) |=> st_reg.ovf[0];
    endproperty
    a_pri_ovf: assert property (p_pri_ovf)
        else $error("primary overflow not flagged at the bottom of the range");

    property p_velocity;
        SAMPLE_I && st_reg.primed |=> st_reg.vel == 16'($past(PRIM_ANGLE_I) - $past(st_reg.prim_angle));
    endproperty
    a_velocity: assert property (p_velocity)
        else $error("velocity is not the first difference of the primary angle");

    property p_hyst_hold;
        !SAMPLE_I |=> $stable(ENCODER_OUTPUT_ANGLE_O);
    endproperty
    a_hyst_hold: assert property (p_hyst_hold)
        else $error("encoder angle changed without a new sample");

    // The self-test length follows the parameter, so it is checked at its last count.
    property p_bist_len;
        BIST_FORCE_O && (st_reg.bist_cnt == BIST_LAST) |=> !BIST_FORCE_O;
    endproperty
    a_bist_len: assert property (p_bist_len)
        else $error("self-test did not end after its last cycle");

    property p_accel;
        SAMPLE_I && st_reg.primed |=> st_reg.accel == 16'(st_reg.vel - $past(st_reg.vel));
    endproperty
    a_accel: assert property (p_accel)
        else $error("acceleration is not the first difference of the velocity");

    property p_secondary_angle;
        SAMPLE_I |=> st_reg.secondary_angle == $past(SECONDARY_ANGLE_I);
    endproperty
    a_secondary_angle: assert property (p_secondary_angle)
        else $error("secondary angle register did not take the new sample");

    property p_snap_hold;
        !(RD_EN_I && (RD_ADDR_I == `ATR_OFS_PRIM_ANGLE))
            |=> $stable(st_reg.sec_snap) && $stable(st_reg.prim_turns_snap);
    endproperty
    a_snap_hold: assert property (p_snap_hold)
        else $error("snapshot changed without a primary angle read");

    property p_turns_hold;
        !SAMPLE_I && !TURNS_RESET_I |=> $stable(st_reg.turns);
    endproperty
    a_turns_hold: assert property (p_turns_hold)
        else $error("turn count changed without a sample");

    property p_sec_step;
        SAMPLE_I && st_reg.primed && !TURNS_RESET_I
            && (SECONDARY_ANGLE_I[15:14] == st_reg.secondary_angle[15:14] + 2'h1)
            |=> st_reg.turns[1] == $past(st_reg.turns[1]) + 11'h001;
    endproperty
    a_sec_step: assert property (p_sec_step)
        else $error("secondary count did not follow a forward quadrant step");

    property p_turns_clear;
        TURNS_RESET_I |=> (st_reg.turns[0] == 11'h000) && (st_reg.turns[1] == 11'h000);
    endproperty
    a_turns_clear: assert property (p_turns_clear)
        else $error("turn counts not zeroed by the turns reset command");

endmodule : atr_readout

// ===== sim/atr_env_model.sv
// Fault source model that stands around the readout and answers its self-test.
`timescale 1ns/10ps
module atr_env_model (
    // Self-test handshake
    input wire logic bist_force_i,
    input wire logic break_bist_i,
    // Fault levels
    input wire logic [5:0] fault_req_i,
    output logic [5:0] fault_o
);
    assign fault_o = (bist_force_i && !break_bist_i) ? 6'h3f : fault_req_i;
endmodule : atr_env_model

// ===== sim/tb_top.sv
// Self-checking bench with a reference model of the angle and turns readout.
`timescale 1ns/10ps
module tb_top;
    import atr_pkg::*;
    localparam int BC = 2;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic smp = 1'b0;
    logic sel = 1'b0;
    logic lp = 1'b0;
    logic trst = 1'b0;
    logic ren = 1'b0;
    logic brk = 1'b0;
    logic bforce;
    logic [2:0] hs = 3'h0;
    logic [5:0] freq = 6'h00;
    logic [5:0] flt;
    logic [7:0] radr = 8'h00;
    logic [15:0] pa = 16'h0000;
    logic [15:0] sa = 16'h0000;
    logic [15:0] rdat;
    logic [15:0] enc;
    int miscompares = 0;
    int checked = 0;
    logic [31:0] rs = 32'h21;
    logic [10:0] pc, sc;
    logic pov, sov, bf, primed;
    logic [15:0] mp, ms, mv, ma, mh, snap_s, snap_p;
    logic [7:0] addrs[$] = '{8'h10, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h20};

    atr_readout #(.BIST_CYCLES(BC)) u_atr_readout (.CLK_SYS_I(clk), .RST_B_I(rst_b), .SAMPLE_I(smp),
        .PRIM_ANGLE_I(pa), .SECONDARY_ANGLE_I(sa), .ENC_CHAN_SEL_I(sel), .HYSTERESIS_SETTING_I(hs),
        .FAULT_I(flt), .LOW_POWER_I(lp), .TURNS_RESET_I(trst), .RD_EN_I(ren), .RD_ADDR_I(radr),
        .RD_DATA_O(rdat), .ENCODER_OUTPUT_ANGLE_O(enc), .BIST_FORCE_O(bforce));
    atr_env_model u_atr_env_model (.bist_force_i(bforce), .break_bist_i(brk), .fault_req_i(freq), .fault_o(flt));

    always #25 clk = ~clk;

    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : xs

    function automatic logic [15:0] expv(input logic [7:0] a);
        logic pw, sw;
        pw = freq[0] | freq[2] | freq[5] | bf;
        sw = (|freq[5:1]) | bf;
        case (a)
            8'h10: return mp;
            8'h15: return {2'h0, pw, pov, 1'h0, pc};
            8'h16: return mh;
            8'h17: return mv;
            8'h18: return ma;
            8'h19: return ms;
            8'h1a: return snap_s;
            8'h1b: return snap_p;
            8'h1c: return {2'h0, sw, sov, 1'h0, sc};
            default: return 16'h0000;
        endcase
    endfunction : expv

    function automatic logic [15:0] nxt(input logic [15:0] o, input int d);
        if (d == 0) begin
            return o + 16'(xs() % 48) - 16'h0018;
        end
        return {o[15:14] + 2'(d), 14'(xs())};
    endfunction : nxt

    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", name, e, g);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    task automatic rd(input logic [7:0] a);
        logic [15:0] e;
        e = expv(a);
        @(negedge clk);
        ren = 1'b1;
        radr = a;
        if (a == 8'h10) begin
            snap_s = ms;
            snap_p = expv(8'h15);
        end
        @(negedge clk);
        ren = 1'b0;
        @(negedge clk);
        chk($sformatf("reg %h", a), e, rdat);
        chk("encoder angle", mh, enc);
    endtask : rd

    task automatic turn(input logic [15:0] o, input logic [15:0] n, inout logic [10:0] c, inout logic v,
        input logic [10:0] mn);
        logic [1:0] q;
        q = n[15:14] - o[15:14];
        if (q == 2'h1) begin
            v = v | (c == 11'h3ff);
            c = c + 11'h001;
        end else if (q == 2'h3) begin
            v = v | (c == mn);
            c = c - 11'h001;
        end
    endtask : turn

    task automatic step(input int dp, input int ds);
        logic [15:0] np, ns, nv, sa_sel;
        int d;
        np = nxt(mp, dp);
        ns = nxt(ms, ds);
        void'(xs());
        @(negedge clk);
        smp = 1'b1;
        pa = np;
        sa = ns;
        sel = rs[0];
        hs = rs[3:1];
        @(negedge clk);
        smp = 1'b0;
        sa_sel = sel ? ns : np;
        d = int'($signed(sa_sel - mh));
        if (primed) begin
            turn(mp, np, pc, pov, 11'h400);
            turn(ms, ns, sc, sov, 11'h401);
            nv = np - mp;
            ma = nv - mv;
            mv = nv;
            if (d > (int'(hs) << 2) || -d > (int'(hs) << 2)) begin
                mh = sa_sel;
            end
        end else begin
            mh = sa_sel;
        end
        primed = 1'b1;
        mp = np;
        ms = ns;
    endtask : step

    task automatic tres();
        @(negedge clk);
        trst = 1'b1;
        @(negedge clk);
        trst = 1'b0;
        pc = 11'h000;
        sc = 11'h000;
        pov = 1'b0;
        sov = 1'b0;
    endtask : tres

    task automatic lp_exit();
        int n;
        n = 0;
        @(negedge clk);
        lp = 1'b1;
        @(negedge clk);
        lp = 1'b0;
        repeat (BC + 3) begin
            @(negedge clk);
            n += int'(bforce);
        end
        chk("self-test length", 16'(BC), 16'(n));
    endtask : lp_exit

    task automatic do_reset();
        int n;
        @(negedge clk);
        rst_b = 1'b0;
        {pc, sc, pov, sov, bf, primed} = '0;
        {mp, ms, mv, ma, mh, snap_s, snap_p} = '0;
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        n = 0;
        while (n < 20 && bforce !== 1'b0) begin
            @(negedge clk);
            n++;
        end
        chk("self-test length", 16'(BC), 16'(n));
    endtask : do_reset

    initial begin
        #(60000 * 50);
        miscompares++;
        report_and_stop();
    end

    initial begin
        do_reset();
        foreach (addrs[i]) rd(addrs[i]);
        for (int i = 0; i < 40; i++) begin
            freq = 6'(xs());
            step(int'(xs() % 4), int'(xs() % 4));
            foreach (addrs[j]) rd(addrs[j]);
        end
        freq = 6'h00;
        tres();
        repeat (1024) step(1, 1);
        foreach (addrs[j]) rd(addrs[j]);
        tres();
        rd(8'h15);
        repeat (1024) step(3, 3);
        rd(8'h1c);
        rd(8'h15);
        step(3, 3);
        rd(8'h15);
        rd(8'h1c);
        lp_exit();
        rd(8'h1c);
        brk = 1'b1;
        lp_exit();
        brk = 1'b0;
        bf = 1'b1;
        rd(8'h1c);
        lp_exit();
        repeat (20) @(negedge clk);
        rd(8'h1c);
        rd(8'h15);
        do_reset();
        rd(8'h1c);
        report_and_stop();
    end
endmodule : tb_top
